// File: inc/irq_regs_cfg.svh
// Register indices, field positions and reset values of the irq registers
`ifndef IRQ_REGS_CFG_SVH
`define IRQ_REGS_CFG_SVH

// Register indices; the byte address is four times the index
`define IDX_ENABLE_TWO   6'h11
`define IDX_REQUEST_ONE  6'h16
`define IDX_ENABLE_ONE   6'h18
`define IDX_IRQ_STATUS   6'h19
`define IDX_IRQ_MASK     6'h1a

// Field positions in the request register
`define BIT_PORTB_CHANGE 7
`define BIT_TIMER3       6
`define BIT_TIMER2       5
`define BIT_TIMER1       4
`define BIT_CAPTURE2     3
`define BIT_CAPTURE1     2
`define BIT_SER1_TX      1
`define BIT_SER1_RX      0

// Writable bits: enable-two bit 4 is absent, request bits 1:0 are status
`define WMASK_ENABLE_TWO  8'hef
`define WMASK_REQUEST_ONE 8'hfc

// Reset values
`define RST_ENABLE_TWO   8'h00
`define RST_REQUEST_ONE  8'h00
`define RST_SER1_TX      1'b1
`define RST_SER1_RX      1'b0
`define RST_ENABLE_ONE   8'h00
`define RST_IRQ_STATUS   8'h00
`define RST_IRQ_MASK     8'h00

// Bus response codes
`define RESP_OKAY        2'h0
`define RESP_DECERR      2'h3

// Timer 3 overflow is a roll from all ones
`define TIMER3_FULL      16'hffff

`endif

// File: inc/irq_regs_pkg.sv
// Types shared by the peripheral interrupt register block
package irq_regs_pkg;

    // One eight-bit register image
    typedef logic [7:0] reg8_t;

    // Write channel progress
    typedef enum logic {WR_COLLECT, WR_RESPOND} wr_state_e;

endpackage

// File: logic/bit_sync.sv
// Two-flop synchroniser for a group of independent pin levels
module bit_sync
#(
    parameter int W = 1
)
(
    input  wire logic         CLK,
    input  wire logic         SRST,
    input  wire logic [W-1:0] PIN_IN,
    output logic      [W-1:0] SYNC_OUT
);

    // First stage, read only by the second stage
    logic [W-1:0] meta_r;

    // Both stages clear on reset
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            meta_r   <= '0;
            SYNC_OUT <= '0;
        end
        else
        begin
            meta_r   <= PIN_IN;
            SYNC_OUT <= meta_r;
        end
    end

endmodule

// File: logic/rollover_detect.sv
// Pulses once when a count returns to zero from its period value
module rollover_detect
#(
    parameter int W = 16
)
(
    input  wire logic         CLK,
    input  wire logic         SRST,
    input  wire logic [W-1:0] COUNT,
    input  wire logic [W-1:0] PERIOD,
    output logic              HIT
);

    // Count equalled the period on the previous cycle
    logic at_period_r;

    // Remember the match, then fire when the next value is zero
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            at_period_r <= 1'b0;
            HIT         <= 1'b0;
        end
        else
        begin
            at_period_r <= (COUNT == PERIOD);
            HIT         <= at_period_r && (COUNT == '0);
        end
    end

endmodule

// File: logic/periph_irq_regs.sv
// Peripheral interrupt enable and request registers behind AXI4-Lite
//
// Register access over AXI4-Lite was chosen for this implementation.
`include "irq_regs_cfg.svh"

module periph_irq_regs
#(
    parameter int ADDR_W = 8,
    parameter int PORTB_W = 8
)
(
    input  wire logic               CLK,
    input  wire logic               SRST,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0]  S_AXI_AWADDR,
    input  wire logic               S_AXI_AWVALID,
    output logic                    S_AXI_AWREADY,
    input  wire logic [31:0]        S_AXI_WDATA,
    input  wire logic [3:0]         S_AXI_WSTRB,
    input  wire logic               S_AXI_WVALID,
    output logic                    S_AXI_WREADY,
    output logic [1:0]              S_AXI_BRESP,
    output logic                    S_AXI_BVALID,
    input  wire logic               S_AXI_BREADY,
    input  wire logic [ADDR_W-1:0]  S_AXI_ARADDR,
    input  wire logic               S_AXI_ARVALID,
    output logic                    S_AXI_ARREADY,
    output logic [31:0]             S_AXI_RDATA,
    output logic [1:0]              S_AXI_RRESP,
    output logic                    S_AXI_RVALID,
    input  wire logic               S_AXI_RREADY,
    // Pins, asynchronous
    input  wire logic [PORTB_W-1:0] PORTB_PINS,
    input  wire logic               CAPTURE_INPUT_ONE,
    input  wire logic               CAPTURE_INPUT_TWO,
    // Core and peripheral signals, same clock
    input  wire logic               PORTB_READ,
    input  wire logic [7:0]         TIMER_ONE,
    input  wire logic [7:0]         TIMER_TWO,
    input  wire logic [15:0]        TIMER_THREE,
    input  wire logic [7:0]         TIMER1_PERIOD,
    input  wire logic [7:0]         TIMER2_PERIOD,
    input  wire logic [15:0]        TIMER3_PERIOD_PAIR,
    input  wire logic               CAPTURE_OR_PERIOD_SELECT,
    input  wire logic               TIMER_PAIR_16BIT_SEL,
    input  wire logic               SER1_TX_EMPTY,
    input  wire logic               SER1_RX_FULL,
    input  wire logic [7:0]         REQUEST_TWO_FLAGS,
    // Register images and interrupt outputs
    output logic [7:0]              ENABLE_TWO_BITS,
    output logic [7:0]              REQUEST_ONE_BITS,
    output logic                    PERIPH_SUMMARY_FLAG,
    output logic                    IRQ
);

    // Word index of a byte address
    function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] a);
        reg_index = 6'(a[ADDR_W-1:2]);
    endfunction

    // True for every index that holds a register
    function automatic logic is_mapped(input logic [5:0] idx);
        is_mapped = (idx == `IDX_ENABLE_TWO) || (idx == `IDX_REQUEST_ONE) ||
                    (idx == `IDX_ENABLE_ONE) || (idx == `IDX_IRQ_STATUS) ||
                    (idx == `IDX_IRQ_MASK);
    endfunction

    // Register state
    irq_regs_pkg::reg8_t enable_two_r;   // Second enable register
    irq_regs_pkg::reg8_t enable_one_r;   // Companion enables for flags
    logic [7:2]          req_flags_r;    // Event flags, bits 7..2
    irq_regs_pkg::reg8_t irq_status_r;   // Sticky event record
    irq_regs_pkg::reg8_t irq_mask_r;     // Gates status onto IRQ
    logic                ser1_tx_r;      // Transmit empty level
    logic                ser1_rx_r;      // Receive full level
    irq_regs_pkg::reg8_t request_view;   // Request register as read

    // Write channel
    irq_regs_pkg::wr_state_e wr_state_r;
    logic                aw_held_r;      // Address taken, not yet used
    logic                w_held_r;       // Data taken, not yet used
    logic [5:0]          wr_idx_r;       // Index of the pending write
    logic [7:0]          wr_data_r;      // Low byte of the write data
    logic                wr_lane_r;      // Low byte lane enabled
    logic                wr_fire;        // Apply the pending write now
    logic [1:0]          bresp_r;

    // Read channel
    logic                rd_take;        // Read address handshake
    logic [5:0]          rd_idx;
    logic [31:0]         rdata_r;
    logic [1:0]          rresp_r;
    logic                rvalid_r;

    // Event sources
    logic [PORTB_W+1:0]  pins_s;         // Synchronised pin levels
    logic [PORTB_W-1:0]  portb_latch_r;  // Level seen at the last read
    logic                primed_r;       // Latch loaded after reset
    logic [1:0]          cap_prev_r;     // Capture levels, one cycle old
    logic                t1_hit;
    logic                t2_hit;
    logic                t3_hit;
    logic [7:0]          events;         // Hardware set requests
    logic [15:0]         t1_count;
    logic [15:0]         t1_period;
    logic [15:0]         t3_period;

    // Pin synchronisers; only the second stage reads the first stage
    bit_sync #(.W(PORTB_W + 2)) u_pin_sync
    (
        .CLK      (CLK),
        .SRST     (SRST),
        .PIN_IN   ({PORTB_PINS, CAPTURE_INPUT_TWO, CAPTURE_INPUT_ONE}),
        .SYNC_OUT (pins_s)
    );

    // Timer 3: overflow from all ones, or roll from the period pair
    // overflow in capture mode
    assign t3_period = CAPTURE_OR_PERIOD_SELECT ? `TIMER3_FULL
                                                : TIMER3_PERIOD_PAIR;

    rollover_detect #(.W(16)) u_timer3
    (
        .CLK    (CLK),
        .SRST   (SRST),
        .COUNT  (TIMER_THREE),
        .PERIOD (t3_period),
        .HIT    (t3_hit)
    );

    rollover_detect #(.W(8)) u_timer2
    (
        .CLK    (CLK),
        .SRST   (SRST),
        .COUNT  (TIMER_TWO),
        .PERIOD (TIMER2_PERIOD),
        .HIT    (t2_hit)
    );

    // Timer 1 alone, or paired with timer 2 as the upper byte
    // eight-bit roll
    assign t1_count  = TIMER_PAIR_16BIT_SEL ? {TIMER_TWO, TIMER_ONE}
                                            : {8'h00, TIMER_ONE};
    assign t1_period = TIMER_PAIR_16BIT_SEL ? {TIMER2_PERIOD, TIMER1_PERIOD}
                                            : {8'h00, TIMER1_PERIOD};

    rollover_detect #(.W(16)) u_timer1
    (
        .CLK    (CLK),
        .SRST   (SRST),
        .COUNT  (t1_count),
        .PERIOD (t1_period),
        .HIT    (t1_hit)
    );

    // Port latch: reloaded when the core reads the port, and once
    // after reset, while the synchroniser still gives zero, so static high pins raise a change
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            portb_latch_r <= '0;
            primed_r      <= 1'b0;
        end
        else
        begin
            primed_r <= 1'b1;
            if (PORTB_READ || !primed_r)
            begin
                portb_latch_r <= pins_s[PORTB_W+1:2];
            end
        end
    end

    // Capture pins are edge events; rising edge counts as a capture
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            cap_prev_r <= 2'h0;
        end
        else
        begin
            cap_prev_r <= pins_s[1:0];
        end
    end

    // Collect the events; none of them looks at any enable
    always_comb
    begin
        events = 8'h00;
        events[`BIT_PORTB_CHANGE] = primed_r &&
                                    (pins_s[PORTB_W+1:2] != portb_latch_r);
        events[`BIT_TIMER3]       = t3_hit;
        events[`BIT_TIMER2]       = t2_hit;
        events[`BIT_TIMER1]       = t1_hit;
        events[`BIT_CAPTURE2]     = pins_s[1] && !cap_prev_r[1];
        events[`BIT_CAPTURE1]     = pins_s[0] && !cap_prev_r[0];
    end

    // Flag bits: a flag holds whatever software wrote until an event
    // set ignores enables
    genvar gi;
    generate
        for (gi = 2; gi < 8; gi++)
        begin : g_flag
            always_ff @(posedge CLK)
            begin
                if (SRST)
                begin
                    req_flags_r[gi] <= 1'(`RST_REQUEST_ONE >> gi);
                end
                else if (events[gi])
                begin
                    req_flags_r[gi] <= 1'b1;
                end
                else if (wr_fire && wr_lane_r &&
                         wr_idx_r == `IDX_REQUEST_ONE)
                begin
                    req_flags_r[gi] <= wr_data_r[gi];
                end
            end
        end
    endgenerate

    // Serial channel levels, owned by hardware, writes ignored
    // transmit empty level
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            ser1_tx_r <= `RST_SER1_TX;
            ser1_rx_r <= `RST_SER1_RX;
        end
        else
        begin
            ser1_tx_r <= SER1_TX_EMPTY;
            ser1_rx_r <= SER1_RX_FULL;
        end
    end

    // Request register as software and the summary see it
    always_comb
    begin
        request_view = {req_flags_r, 2'h0};
        request_view[`BIT_SER1_TX] = ser1_tx_r;
        request_view[`BIT_SER1_RX] = ser1_rx_r;
    end

    // Enable and mask registers; unimplemented bits never store
    // upper enables writable
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            enable_two_r <= `RST_ENABLE_TWO;
            enable_one_r <= `RST_ENABLE_ONE;
            irq_mask_r   <= `RST_IRQ_MASK;
        end
        else if (wr_fire && wr_lane_r)
        begin
            case (wr_idx_r)
                `IDX_ENABLE_TWO: enable_two_r <= wr_data_r & `WMASK_ENABLE_TWO;
                `IDX_ENABLE_ONE: enable_one_r <= wr_data_r;
                `IDX_IRQ_MASK:   irq_mask_r   <= wr_data_r;
                default:         ;
            endcase
        end
    end

    // Sticky status: events set, a read of the register clears;
    // an event in the clearing cycle survives
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            irq_status_r <= `RST_IRQ_STATUS;
        end
        else if (rd_take && rd_idx == `IDX_IRQ_STATUS)
        begin
            irq_status_r <= events;
        end
        else
        begin
            irq_status_r <= irq_status_r | events;
        end
    end

    // Summary flag and interrupt line, both registered levels
    // flag and enable
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            PERIPH_SUMMARY_FLAG <= 1'b0;
            IRQ                 <= 1'b0;
        end
        else
        begin
            PERIPH_SUMMARY_FLAG <= |(request_view & enable_one_r) ||
                                   |(REQUEST_TWO_FLAGS & enable_two_r);
            IRQ                 <= |(irq_status_r & irq_mask_r);
        end
    end

    // Write channel: address and data are taken in either order and
    // the write is applied one cycle after both are held
    assign S_AXI_AWREADY = (wr_state_r == irq_regs_pkg::WR_COLLECT) &&
                           !aw_held_r;
    assign S_AXI_WREADY  = (wr_state_r == irq_regs_pkg::WR_COLLECT) &&
                           !w_held_r;
    assign wr_fire       = (wr_state_r == irq_regs_pkg::WR_COLLECT) &&
                           aw_held_r && w_held_r;

    // Hold the write address
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            aw_held_r <= 1'b0;
            wr_idx_r  <= 6'h00;
        end
        else if (S_AXI_AWVALID && S_AXI_AWREADY)
        begin
            aw_held_r <= 1'b1;
            wr_idx_r  <= reg_index(S_AXI_AWADDR);
        end
        else if (wr_fire)
        begin
            aw_held_r <= 1'b0;
        end
    end

    // Hold the write data; only the low byte lane carries bits
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            w_held_r  <= 1'b0;
            wr_data_r <= 8'h00;
            wr_lane_r <= 1'b0;
        end
        else if (S_AXI_WVALID && S_AXI_WREADY)
        begin
            w_held_r  <= 1'b1;
            wr_data_r <= S_AXI_WDATA[7:0];
            wr_lane_r <= S_AXI_WSTRB[0];
        end
        else if (wr_fire)
        begin
            w_held_r <= 1'b0;
        end
    end

    // Response: unmapped addresses answer with a decode error
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            wr_state_r <= irq_regs_pkg::WR_COLLECT;
            bresp_r    <= `RESP_OKAY;
        end
        else
        begin
            case (wr_state_r)
                irq_regs_pkg::WR_COLLECT:
                begin
                    if (wr_fire)
                    begin
                        wr_state_r <= irq_regs_pkg::WR_RESPOND;
                        bresp_r    <= is_mapped(wr_idx_r) ? `RESP_OKAY
                                                          : `RESP_DECERR;
                    end
                end
                irq_regs_pkg::WR_RESPOND:
                begin
                    if (S_AXI_BREADY)
                    begin
                        wr_state_r <= irq_regs_pkg::WR_COLLECT;
                    end
                end
                default:
                begin
                    wr_state_r <= irq_regs_pkg::WR_COLLECT;
                end
            endcase
        end
    end

    assign S_AXI_BVALID = (wr_state_r == irq_regs_pkg::WR_RESPOND);
    assign S_AXI_BRESP  = bresp_r;

    // Read channel: one read at a time, data registered on the take
    assign S_AXI_ARREADY = !rvalid_r;
    assign rd_take       = S_AXI_ARVALID && S_AXI_ARREADY;
    assign rd_idx        = reg_index(S_AXI_ARADDR);

    // Read mux; upper 24 bits and missing bits read as zero
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= `RESP_OKAY;
        end
        else if (rd_take)
        begin
            rvalid_r <= 1'b1;
            rresp_r  <= is_mapped(rd_idx) ? `RESP_OKAY : `RESP_DECERR;
            case (rd_idx)
                `IDX_ENABLE_TWO:  rdata_r <= {24'h0, enable_two_r};
                `IDX_REQUEST_ONE: rdata_r <= {24'h0, request_view};
                `IDX_ENABLE_ONE:  rdata_r <= {24'h0, enable_one_r};
                `IDX_IRQ_STATUS:  rdata_r <= {24'h0, irq_status_r};
                `IDX_IRQ_MASK:    rdata_r <= {24'h0, irq_mask_r};
                default:          rdata_r <= 32'h0000_0000;
            endcase
        end
        else if (S_AXI_RREADY)
        begin
            rvalid_r <= 1'b0;
        end
    end

    assign S_AXI_RVALID = rvalid_r;
    assign S_AXI_RDATA  = rdata_r;
    assign S_AXI_RRESP  = rresp_r;

    // Register images for the core side
    assign ENABLE_TWO_BITS  = enable_two_r;
    assign REQUEST_ONE_BITS = request_view;

endmodule

// File: tb/periph_irq_regs_chk.sv
// Port assertions for the peripheral irq registers
module periph_irq_regs_chk
(
    input wire logic       CLK,
    input wire logic       SRST,
    input wire logic       S_AXI_BVALID,
    input wire logic       CAPTURE_INPUT_ONE,
    input wire logic [7:0] TIMER_ONE,
    input wire logic [7:0] TIMER_TWO,
    input wire logic [7:0] TIMER1_PERIOD,
    input wire logic [7:0] TIMER2_PERIOD,
    input wire logic       TIMER_PAIR_16BIT_SEL,
    input wire logic       SER1_TX_EMPTY,
    input wire logic       SER1_RX_FULL,
    input wire logic [7:0] REQUEST_TWO_FLAGS,
    input wire logic [7:0] ENABLE_TWO_BITS,
    input wire logic [7:0] REQUEST_ONE_BITS,
    input wire logic       PERIPH_SUMMARY_FLAG
);
    timeunit 1ns;
    timeprecision 1ps;

    // One clock; checks rest during reset
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SRST);

    // Timer one at period, then zero
    sequence roll_one;
        !TIMER_PAIR_16BIT_SEL && TIMER_ONE == TIMER1_PERIOD
            ##1 TIMER_ONE == 8'h00;
    endsequence

    // Timer two at period, then zero
    sequence roll_two;
        TIMER_TWO == TIMER2_PERIOD
            ##1 TIMER_TWO == 8'h00;
    endsequence

    t1_roll_a:
        assert property (roll_one |-> ##[1:5] REQUEST_ONE_BITS[4])
        else $error("timer one roll left flag clear");
    t2_roll_a:
        assert property (roll_two |-> ##[1:5] REQUEST_ONE_BITS[5])
        else $error("timer two roll left flag clear");
    capture_flag_a:
        assert property ($rose(CAPTURE_INPUT_ONE)
            |-> ##[1:6] REQUEST_ONE_BITS[2])
        else $error("capture edge left flag clear");
    bit4_zero_a:
        assert property (!ENABLE_TWO_BITS[4])
        else $error("absent enable bit set");
    tx_mirror_a:
        assert property (1'b1 |=> REQUEST_ONE_BITS[1] == $past(SER1_TX_EMPTY))
        else $error("transmit status bit wrong");
    rx_mirror_a:
        assert property (1'b1 |=> REQUEST_ONE_BITS[0] == $past(SER1_RX_FULL))
        else $error("receive status bit wrong");
    summary_or_a:
        assert property (|(REQUEST_TWO_FLAGS & ENABLE_TWO_BITS)
            |=> PERIPH_SUMMARY_FLAG)
        else $error("summary low with enabled flag");
    flag_hold_a:
        assert property (|($past(REQUEST_ONE_BITS[7:2]) &
            ~REQUEST_ONE_BITS[7:2])
            |-> $rose(S_AXI_BVALID))
        else $error("flag cleared without a write");
    enable_hold_a:
        assert property (!$stable(ENABLE_TWO_BITS) |-> $rose(S_AXI_BVALID))
        else $error("enable changed without a write");
endmodule

bind periph_irq_regs periph_irq_regs_chk chk_i
(
    .CLK(CLK), .SRST(SRST), .S_AXI_BVALID(S_AXI_BVALID),
    .CAPTURE_INPUT_ONE(CAPTURE_INPUT_ONE), .TIMER_ONE(TIMER_ONE),
    .TIMER_TWO(TIMER_TWO), .TIMER1_PERIOD(TIMER1_PERIOD),
    .TIMER2_PERIOD(TIMER2_PERIOD),
    .TIMER_PAIR_16BIT_SEL(TIMER_PAIR_16BIT_SEL),
    .SER1_TX_EMPTY(SER1_TX_EMPTY), .SER1_RX_FULL(SER1_RX_FULL),
    .REQUEST_TWO_FLAGS(REQUEST_TWO_FLAGS),
    .ENABLE_TWO_BITS(ENABLE_TWO_BITS),
    .REQUEST_ONE_BITS(REQUEST_ONE_BITS),
    .PERIPH_SUMMARY_FLAG(PERIPH_SUMMARY_FLAG)
);

// File: tb/periph_model.sv
// Timer model standing in for the on-chip counters
module periph_model
(
    input  wire logic        CLK,
    input  wire logic        SRST,
    input  wire logic [2:0]  RUN,
    input  wire logic        PAIR,
    input  wire logic        OVF,
    input  wire logic [7:0]  P1,
    input  wire logic [7:0]  P2,
    input  wire logic [15:0] P3,
    output logic      [7:0]  T1,
    output logic      [7:0]  T2,
    output logic      [15:0] T3
);
    timeunit 1ns;
    timeprecision 1ps;

    // Counts hold while stopped, so no false roll appears
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            T1 <= 8'h00;
            T2 <= 8'h00;
            T3 <= 16'h0000;
        end
        else
        begin
            // Paired mode: one 16-bit count over both halves
            if (RUN[0] && PAIR)
                {T2, T1} <= ({T2, T1} == {P2, P1}) ? 16'h0000
                                                   : {T2, T1} + 16'h0001;
            else if (RUN[0])
                T1 <= (T1 == P1) ? 8'h00 : T1 + 8'h01;
            if (RUN[1])
                T2 <= (T2 == P2) ? 8'h00 : T2 + 8'h01;
            // Overflow mode wraps past all ones, period ignored
            if (RUN[2])
                T3 <= (!OVF && T3 == P3) ? 16'h0000 : T3 + 16'h0001;
        end
    end
endmodule

// File: tb/tb.sv
// Self-checking bench for the peripheral irq register block
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // Timer periods shared by model and block
    localparam logic [7:0]  P1 = 8'h05;
    localparam logic [7:0]  P2 = 8'h07;
    localparam logic [15:0] P3 = 16'h0009;

    logic        clk;
    logic        srst = 1'b1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] rdata, d;
    logic [7:0]  pins = 8'h00, req2 = 8'h00, t1, t2, en2, req1;
    logic        cap1 = 1'b0, cap2 = 1'b0, pbread = 1'b0, pair = 1'b0;
    logic        ovf = 1'b0, txe = 1'b1, rxf = 1'b0, summ, irq;
    logic [2:0]  run = 3'b000;
    logic [15:0] t3;
    int          n_fail = 0, checked = 0;
    // Timer cases: lanes, pairing, flag, cycles run
    logic [2:0]  runs [4] = '{3'b010, 3'b001, 3'b001, 3'b100};
    logic        prs [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    logic [7:0]  bits [4] = '{8'h20, 8'h10, 8'h10, 8'h40};
    int          waits [4] = '{40, 40, 2000, 40};
    logic [7:0]  ev [3] = '{8'hff, 8'h10, 8'h00};

    periph_irq_regs uut
    (
        .CLK(clk), .SRST(srst),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .PORTB_PINS(pins), .CAPTURE_INPUT_ONE(cap1),
        .CAPTURE_INPUT_TWO(cap2), .PORTB_READ(pbread),
        .TIMER_ONE(t1), .TIMER_TWO(t2), .TIMER_THREE(t3),
        .TIMER1_PERIOD(P1), .TIMER2_PERIOD(P2), .TIMER3_PERIOD_PAIR(P3),
        .CAPTURE_OR_PERIOD_SELECT(ovf), .TIMER_PAIR_16BIT_SEL(pair),
        .SER1_TX_EMPTY(txe), .SER1_RX_FULL(rxf),
        .REQUEST_TWO_FLAGS(req2), .ENABLE_TWO_BITS(en2),
        .REQUEST_ONE_BITS(req1), .PERIPH_SUMMARY_FLAG(summ), .IRQ(irq)
    );

    periph_model pm
    (
        .CLK(clk), .SRST(srst), .RUN(run), .PAIR(pair), .OVF(ovf),
        .P1(P1), .P2(P2), .P3(P3), .T1(t1), .T2(t2), .T3(t3)
    );

    // Free-running clock, 4 ns period
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Wait whole clock cycles
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask

    // Compare one value and count it
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask

    // Bus write; code lands in r
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        r = bresp;
    endtask

    // Bus read; data lands in d, code in r
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready)
                arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask

    // Verdict and end of run
    task automatic results;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Hang guard past the longest run
    initial
    begin
        tick(90000);
        $display("MISMATCH %0t timeout", $time);
        n_fail++;
        results;
    end

    initial
    begin
        tick(3);
        srst <= 1'b0;
        tick(1);
        chk(en2, 32'h0);
        rd(8'h58);
        chk(d, 32'h02);
        // Enables keep writes; the absent bit stays zero
        foreach (ev[i])
        begin
            wr(8'h44, ev[i]);
            rd(8'h44);
            chk(d, ev[i] & 8'hef);
            chk(en2, ev[i] & 8'hef);
        end
        // Unmapped place is refused
        wr(8'h04, 8'hff);
        chk(r, 32'h3);
        rd(8'h04);
        chk(d, 32'h0);
        chk(r, 32'h3);
        // Flags keep writes; serial bits follow their lines
        wr(8'h58, 8'hff);
        rd(8'h58);
        chk(d, 32'hfe);
        txe <= 1'b0;
        rxf <= 1'b1;
        wr(8'h58, 8'h00);
        rd(8'h58);
        chk(d, 32'h01);
        txe <= 1'b1;
        rxf <= 1'b0;
        // Each roll sets its flag with every enable off
        for (int i = 0; i < 4; i++)
        begin
            pair <= prs[i];
            run <= runs[i];
            tick(waits[i]);
            run <= 3'b000;
            tick(8);
            rd(8'h58);
            chk(d & bits[i], bits[i]);
            wr(8'h58, 8'h00);
        end
        // Overflow mode ignores the period match
        ovf <= 1'b1;
        run <= 3'b100;
        tick(40);
        rd(8'h58);
        chk(d, 32'h02);
        tick(65560);
        run <= 3'b000;
        rd(8'h58);
        chk(d, 32'h42);
        ovf <= 1'b0;
        wr(8'h58, 8'h00);
        // Captures; the mask passes only capture one to irq
        rd(8'h64);
        wr(8'h68, 8'h04);
        cap2 <= 1'b1;
        tick(8);
        chk(irq, 32'h0);
        cap1 <= 1'b1;
        tick(8);
        chk(irq, 32'h1);
        rd(8'h58);
        chk(d, 32'h0e);
        rd(8'h64);
        chk(d, 32'h0c);
        rd(8'h64);
        chk(d, 32'h00);
        chk(irq, 32'h0);
        cap1 <= 1'b0;
        cap2 <= 1'b0;
        wr(8'h58, 8'h00);
        // Port change flag returns while the mismatch lasts
        pins <= 8'h01;
        tick(6);
        wr(8'h58, 8'h00);
        rd(8'h58);
        chk(d, 32'h82);
        pbread <= 1'b1;
        tick(1);
        pbread <= 1'b0;
        wr(8'h58, 8'h00);
        rd(8'h58);
        chk(d, 32'h02);
        // Summary needs flag and enable together
        req2 <= 8'h24;
        tick(2);
        chk(summ, 32'h0);
        wr(8'h58, 8'h00);
        wr(8'h44, 8'h04);
        tick(2);
        chk(summ, 32'h1);
        req2 <= 8'h00;
        tick(2);
        chk(summ, 32'h0);
        results;
    end
endmodule
